/* include/sioa_map.svh */
// Constants for the servo I/O function allocation block.
// Assumes inclusion by bare name from the package and the design file.
`ifndef SIOA_MAP_SVH
`define SIOA_MAP_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define SIOA_OFF_IN_A      12'h000
`define SIOA_OFF_IN_B      12'h004
`define SIOA_OFF_OUT       12'h008
`define SIOA_OFF_POL       12'h00c
`define SIOA_OFF_FUNC_IN   12'h010
`define SIOA_OFF_FUNC_OUT  12'h014
`define SIOA_OFF_PIN_STAT  12'h018

// ----------------------------------------------------------------------
// Reset values and field layout
// ----------------------------------------------------------------------
`define SIOA_RST_IN_A      32'h0000_3210
`define SIOA_RST_IN_B      32'h0000_0005
`define SIOA_RST_OUT       32'h0000_0210
`define SIOA_RST_POL       32'h0000_0000
`define SIOA_FIELD_W       4
`define SIOA_IN_A_FIELDS   4
`define SIOA_IN_PINS       5
`define SIOA_OUT_PINS      3
`define SIOA_IN_FUNCS      11
`define SIOA_OUT_FUNCS     14

`endif

/* include/sioa_pkg.sv */
// Types for the servo I/O function allocation block.
// Assumes sioa_map.svh is on the include path.
`include "sioa_map.svh"
package sioa_pkg;
  // Input function codes
  typedef enum logic [3:0] {
    SIOA_IN_SERVO_ON   = 4'h0,
    SIOA_IN_FWD_PROH   = 4'h1,
    SIOA_IN_REV_PROH   = 4'h2,
    SIOA_IN_FWD_TLIM   = 4'h3,
    SIOA_IN_REV_TLIM   = 4'h4,
    SIOA_IN_GAIN_SEL   = 4'h5,
    SIOA_IN_HOMING     = 4'h6,
    SIOA_IN_REMOTE     = 4'h7,
    SIOA_IN_PROBE_ONE  = 4'h8,
    SIOA_IN_PROBE_TWO  = 4'h9,
    SIOA_IN_FORCE_STOP = 4'ha
  } sioa_in_code_t;

  // Output function codes
  typedef enum logic [3:0] {
    SIOA_OUT_POS_MATCH = 4'h0,
    SIOA_OUT_ROTATION  = 4'h1,
    SIOA_OUT_READY     = 4'h2,
    SIOA_OUT_TLIMITING = 4'h3,
    SIOA_OUT_BRAKE     = 4'h4,
    SIOA_OUT_INDEX     = 4'h5,
    SIOA_OUT_OVERTRAV  = 4'h6,
    SIOA_OUT_EXCITE    = 4'h7,
    SIOA_OUT_TDETECT   = 4'h8,
    SIOA_OUT_HOST_ZERO = 4'ha,
    SIOA_OUT_HOST_ONE  = 4'hb,
    SIOA_OUT_RESERVED  = 4'hc,
    SIOA_OUT_POS_CMP   = 4'hd
  } sioa_out_code_t;

  // Decoded input functions toward the drive core
  typedef struct packed {
    logic force_stop;
    logic probe_in_two;
    logic probe_in_one;
    logic remote_in;
    logic homing_ref_in;
    logic gain_select;
    logic rev_ext_torque_lim_in;
    logic fwd_ext_torque_lim_in;
    logic rev_prohibit_in;
    logic fwd_prohibit_in;
    logic servo_on;
  } sioa_in_func_t;

  // Output functions from the drive core
  typedef struct packed {
    logic position_compare_out;
    logic host_driven_output_one;
    logic host_driven_output_zero;
    logic torque_detect_out;
    logic motor_excite_out;
    logic overtravel_out;
    logic index_pulse_out;
    logic brake_release_out;
    logic torque_limiting_out;
    logic servo_ready_out;
    logic rotation_detect_out;
    logic position_or_speed_match_out;
  } sioa_out_func_t;

  // APB request from the master
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } sioa_apb_req_t;

  // APB answer from the slave
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } sioa_apb_rsp_t;
endpackage

/* design/sioa_alloc.sv */
// Servo I/O function allocation: routes connector pins to drive functions.
// Assumes one clock pclk, asynchronous active-low presetn, APB register
// access, and pin inputs already synchronous to pclk.
//
// Contract
// - Five input pins, each selected by its own field of two parameters.
// - Each input pin drives one function only, the one its field names.
// - One function on several pins: only highest pin counts, descending order.
// - Input codes 0-4: servo-on, fwd/rev prohibit, fwd/rev torque limit.
// - Input codes 5-a: gain, homing, remote, probe one, probe two, stop.
// - Three output pin groups, each selected by its own parameter field.
// - Each output group carries one function only, the one its field names.
// - Output codes 0-4: match, rotation, ready, torque limiting, brake.
// - Output codes 5-8: index pulse, overtravel, excitation, torque detect.
// - Output codes a,b remote outputs, c reserved, d position compare.
// - Default functions preset; parameters change assignment and polarity.
// - Brake drives no group by default, only where field equals 4.
`timescale 1ns/100ps
`include "sioa_map.svh"

module sioa_alloc #(
  parameter int IN_PINS  = `SIOA_IN_PINS,
  parameter int OUT_PINS = `SIOA_OUT_PINS
) (
  input  wire logic                    pclk,        // Bus and logic clock
  input  wire logic                    presetn,     // Async reset, low
  input  wire sioa_pkg::sioa_apb_req_t apb_req,     // APB request
  output sioa_pkg::sioa_apb_rsp_t      apb_rsp,     // APB answer
  input  wire logic [IN_PINS-1:0]      in_pin,      // Input pins, 0=lowest
  output sioa_pkg::sioa_in_func_t      in_func,     // Decoded functions
  input  wire sioa_pkg::sioa_out_func_t out_func,   // Core output states
  output logic [OUT_PINS-1:0]          out_pin      // Output pin groups
);
  import sioa_pkg::*;

  // --------------------------------------------------------------------
  // Field helpers
  // --------------------------------------------------------------------
  // Pick a 4-bit code field from a parameter word
  function automatic logic [3:0] field_of(input logic [31:0] word,
                                          input int idx);
    field_of = word[idx*`SIOA_FIELD_W +: `SIOA_FIELD_W];
  endfunction

  // Exact match of the bus address against one register offset
  function automatic logic addr_is(input logic [11:0] a,
                                   input logic [11:0] off);
    addr_is = (a == off);
  endfunction

  // --------------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------------
  logic [31:0]    in_alloc_a;
  logic [31:0]    in_alloc_b;
  logic [31:0]    out_alloc;
  logic [31:0]    pol;
  logic [31:0]    next_in_alloc_a;
  logic [31:0]    next_in_alloc_b;
  logic [31:0]    next_out_alloc;
  logic [31:0]    next_pol;
  sioa_apb_rsp_t  next_apb_rsp;
  logic           wr_fire;
  logic           rd_hit;
  logic [31:0]    rd_data;

  // Code field per input pin: four in parameter A, last in parameter B
  logic [3:0]     in_code  [IN_PINS];
  logic [3:0]     out_code [OUT_PINS];
  logic [IN_PINS-1:0] in_level;

  // Write strobe on the APB access phase; slave answers with no wait
  assign wr_fire = apb_req.psel & apb_req.penable & apb_req.pwrite;

  // --------------------------------------------------------------------
  // Register next-state and read mux
  // --------------------------------------------------------------------
  always_comb begin
    next_in_alloc_a = in_alloc_a;
    next_in_alloc_b = in_alloc_b;
    next_out_alloc  = out_alloc;
    next_pol        = pol;
    rd_hit          = 1'b1;
    rd_data         = 32'h0000_0000;
    // Parameters steer assignment and polarity
    if (wr_fire) begin
      if (addr_is(apb_req.paddr, `SIOA_OFF_IN_A)) begin
        next_in_alloc_a = {16'h0000, apb_req.pwdata[15:0]};
      end
      if (addr_is(apb_req.paddr, `SIOA_OFF_IN_B)) begin
        next_in_alloc_b = {28'h0000000, apb_req.pwdata[3:0]};
      end
      if (addr_is(apb_req.paddr, `SIOA_OFF_OUT)) begin
        next_out_alloc = {20'h00000, apb_req.pwdata[11:0]};
      end
      if (addr_is(apb_req.paddr, `SIOA_OFF_POL)) begin
        next_pol = {24'h000000, apb_req.pwdata[7:0]};
      end
    end
    case (apb_req.paddr)
      `SIOA_OFF_IN_A:     rd_data = in_alloc_a;
      `SIOA_OFF_IN_B:     rd_data = in_alloc_b;
      `SIOA_OFF_OUT:      rd_data = out_alloc;
      `SIOA_OFF_POL:      rd_data = pol;
      `SIOA_OFF_FUNC_IN:  rd_data = 32'(in_func);
      `SIOA_OFF_FUNC_OUT: rd_data = 32'(out_func);
      `SIOA_OFF_PIN_STAT: rd_data = 32'({out_pin, in_pin});
      default:            rd_hit  = 1'b0;
    endcase
    next_apb_rsp.pready  = 1'b1;
    next_apb_rsp.pslverr = apb_req.psel & ~rd_hit;
    next_apb_rsp.prdata  = rd_hit ? rd_data : 32'h0000_0000;
  end

  // Register update; answer flops feed the bus straight
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_alloc_a <= `SIOA_RST_IN_A;
      in_alloc_b <= `SIOA_RST_IN_B;
      out_alloc  <= `SIOA_RST_OUT;
      pol        <= `SIOA_RST_POL;
      apb_rsp    <= '0;
    end else begin
      in_alloc_a <= next_in_alloc_a;
      in_alloc_b <= next_in_alloc_b;
      out_alloc  <= next_out_alloc;
      pol        <= next_pol;
      apb_rsp    <= next_apb_rsp;
    end
  end

  // --------------------------------------------------------------------
  // Per-pin code fields and polarity
  // --------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < IN_PINS; gi++) begin : g_in
      // Each pin owns one field
      if (gi < `SIOA_IN_A_FIELDS) begin : g_a
        assign in_code[gi] = field_of(in_alloc_a, gi);
      end else begin : g_b
        assign in_code[gi] = field_of(in_alloc_b, gi - `SIOA_IN_A_FIELDS);
      end
      // Polarity inversion per pin
      assign in_level[gi] = in_pin[gi] ^ pol[gi];
    end
    for (gi = 0; gi < OUT_PINS; gi++) begin : g_out
      // Each group owns one field
      assign out_code[gi] = field_of(out_alloc, gi);
    end
  endgenerate

  // --------------------------------------------------------------------
  // Input routing
  // --------------------------------------------------------------------
  sioa_in_func_t  next_in_func;
  logic [`SIOA_IN_FUNCS-1:0] in_vec;
  logic [`SIOA_IN_FUNCS-1:0] in_taken;

  always_comb begin
    in_vec   = '0;
    in_taken = '0;
    // Highest pin first; a function already claimed ignores lower pins
    for (int p = IN_PINS - 1; p >= 0; p--) begin
      for (int f = 0; f < `SIOA_IN_FUNCS; f++) begin
        // The function coded on this pin follows it unless a higher pin took it
        if (in_code[p] == 4'(f) && !in_taken[f]) begin
          in_taken[f] = 1'b1;
          in_vec[f]   = in_level[p];
        end
      end
    end
    // Unclaimed functions stay 0; codes above a are unused
    // Bit order matches codes 0..a
    next_in_func = sioa_in_func_t'(in_vec);
  end

  // --------------------------------------------------------------------
  // Output routing
  // --------------------------------------------------------------------
  logic [`SIOA_OUT_FUNCS-1:0] out_vec;
  logic [OUT_PINS-1:0]        next_out_pin;

  always_comb begin
    // Codes 0..8 in order, 9 unused, a/b remote, c reserved, d compare
    out_vec = {out_func.position_compare_out,
               1'b0,                              // Reserved code c
               out_func.host_driven_output_one,
               out_func.host_driven_output_zero,
               1'b0,                              // Unused code 9
               out_func.torque_detect_out,
               out_func.motor_excite_out,
               out_func.overtravel_out,
               out_func.index_pulse_out,
               out_func.brake_release_out,
               out_func.torque_limiting_out,
               out_func.servo_ready_out,
               out_func.rotation_detect_out,
               out_func.position_or_speed_match_out};
    next_out_pin = '0;
    for (int g = 0; g < OUT_PINS; g++) begin
      // Brake reaches a group only when its field is 4
      // Codes e,f select nothing; the group then shows only its polarity bit
      if (out_code[g] < 4'(`SIOA_OUT_FUNCS)) begin
        next_out_pin[g] = out_vec[out_code[g]];
      end
      next_out_pin[g] = next_out_pin[g] ^ pol[IN_PINS + g];
    end
  end

  // Registered pin-side outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_func <= '0;
      out_pin <= '0;
    end else begin
      in_func <= next_in_func;
      out_pin <= next_out_pin;
    end
  end
endmodule

/* test/sioa_alloc_sva.sv */
// Checker for the I/O allocation block, with a shadow of its registers.
// Assumes it is bound to sioa_alloc and sees only that module's ports.
`timescale 1ns/100ps
module sioa_alloc_sva #(
  parameter int IN_PINS  = 5,
  parameter int OUT_PINS = 3
) (
  input wire logic                     pclk,     // Clock
  input wire logic                     presetn,  // Async reset, low
  input wire sioa_pkg::sioa_apb_req_t  apb_req,  // APB request
  input wire sioa_pkg::sioa_apb_rsp_t  apb_rsp,  // APB answer
  input wire logic [IN_PINS-1:0]       in_pin,   // Input pins
  input wire sioa_pkg::sioa_in_func_t  in_func,  // Decoded functions
  input wire sioa_pkg::sioa_out_func_t out_func, // Core outputs
  input wire logic [OUT_PINS-1:0]      out_pin   // Output groups
);
  import sioa_pkg::*;
  logic [15:0] a, next_a;
  logic [3:0]  b, next_b, c;
  logic [11:0] o, next_o;
  logic [7:0]  p, next_p;
  logic [10:0] ei, asg;
  logic [2:0]  eo, emp;
  logic        wr, bad;
  int          k;
  // --------------------
  // Shadow and reference
  // --------------------
  assign wr  = apb_req.psel & apb_req.penable & apb_req.pwrite;
  assign bad = apb_req.paddr > 12'h018;
  // Next shadow values on a write
  always_comb begin
    {next_a, next_b, next_o, next_p} = {a, b, o, p};
    if (wr) begin
      case (apb_req.paddr)
        12'h000: next_a = apb_req.pwdata[15:0];
        12'h004: next_b = apb_req.pwdata[3:0];
        12'h008: next_o = apb_req.pwdata[11:0];
        12'h00c: next_p = apb_req.pwdata[7:0];
        default: ;
      endcase
    end
  end
  // Shadow registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) {a, b, o, p} <= 40'h3210_5_210_00;
    else {a, b, o, p} <= {next_a, next_b, next_o, next_p};
  end
  // Expected pins; a higher pin overwrites a lower one
  always_comb begin
    ei = '0; asg = '0; eo = '0; emp = '0; c = '0; k = 0;
    for (int i = 0; i < 5; i++) begin
      c = (i == 4) ? b : 4'(a >> (4 * i));
      if (c < 4'hb) begin
        ei[c]  = in_pin[i] ^ p[i];
        asg[c] = 1'b1;
      end
    end
    for (int g = 0; g < 3; g++) begin
      c = 4'(o >> (4 * g));
      emp[g] = (c == 4'h9) | (c == 4'hc) | (c > 4'hd);
      k = (c < 4'h9) ? int'(c) : (c > 4'hb) ? 11 : int'(c) - 1;
      eo[g] = p[5 + g] ^ (!emp[g] & out_func[k]);
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_IN_BASIC:
    assert property ($past(presetn) |-> in_func[4:0] == $past(ei[4:0]))
    else $error("basic input functions wrong");
  AST_IN_EXTRA:
    assert property ($past(presetn) |-> in_func[10:5] == $past(ei[10:5]))
    else $error("further input functions wrong");
  AST_IN_UNUSED:
    assert property ($past(presetn) |-> (in_func & ~$past(asg)) == '0)
    else $error("unassigned input function active");
  AST_OUT_PIN:
    assert property ($past(presetn) |-> out_pin == $past(eo))
    else $error("output group wrong");
  AST_OUT_EMPTY:
    assert property ($past(presetn) |->
      ((out_pin ^ $past(p[7:5])) & $past(emp)) == '0)
    else $error("empty output group active");
  AST_PREADY:
    assert property (apb_req.psel && apb_req.penable |-> apb_rsp.pready)
    else $error("access not answered at once");
  AST_SLVERR:
    assert property (apb_req.psel && !apb_req.penable ##1 apb_req.penable
      && apb_req.paddr[1:0] == 2'b00 |-> apb_rsp.pslverr == bad)
    else $error("slave error flag wrong");
  AST_RD_IN_A:
    assert property (apb_req.psel && apb_req.penable && !apb_req.pwrite
      && apb_req.paddr == 12'h000 |-> apb_rsp.prdata == {16'h0, a})
    else $error("input allocation readback wrong");
endmodule

bind sioa_alloc sioa_alloc_sva #(.IN_PINS(IN_PINS), .OUT_PINS(OUT_PINS))
  u_sva (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
  .apb_rsp(apb_rsp), .in_pin(in_pin), .in_func(in_func),
  .out_func(out_func), .out_pin(out_pin));

/* test/sioa_field.sv */
// Field devices: drive the input pins and watch the output groups.
// Assumes the bench sets the wanted levels just after a clock edge.
`timescale 1ns/100ps
module sioa_field (
  input  wire logic       pclk,    // Clock
  input  wire logic       slow,    // One more edge of delay
  input  wire logic [4:0] want,    // Levels asked by the bench
  output logic      [4:0] in_pin,  // Pins toward the block
  input  wire logic [2:0] out_pin, // Groups from the block
  output logic      [2:0] seen     // Groups as the devices see them
);
  logic [4:0] stage = '0;
  logic [4:0] pins  = '0;
  assign in_pin = pins;
  // Contacts settle one or two edges after a change
  always @(posedge pclk) begin
    stage <= want;
    pins  <= slow ? stage : want;
    seen  <= out_pin;
  end
endmodule

/* test/testbench.sv */
// Bench for the I/O allocation block: registers, pins and polarity.
// Assumes the package, the design, the field model and the checker.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
  n_fail++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module testbench;
  import sioa_pkg::*;
  logic           pclk = 0, presetn = 0, slow = 0, err;
  logic [4:0]     want = '0, in_pin;
  logic [2:0]     out_pin, seen;
  logic [31:0]    rd;
  logic [3:0]     code;
  logic [11:0]    m;
  sioa_apb_req_t  req = '0;
  sioa_apb_rsp_t  rsp;
  sioa_in_func_t  in_func;
  sioa_out_func_t of = '0;
  int             n_fail = 0, check_count = 0, cyc = 0;
  always #10 pclk = ~pclk;
  sioa_alloc dut (.pclk(pclk), .presetn(presetn), .apb_req(req),
    .apb_rsp(rsp), .in_pin(in_pin), .in_func(in_func),
    .out_func(of), .out_pin(out_pin));
  sioa_field field (.pclk(pclk), .slow(slow), .want(want),
    .in_pin(in_pin), .out_pin(out_pin), .seen(seen));
  // ----------------
  // Access and check
  // ----------------
  task automatic bus(input logic w, input logic [11:0] ad,
                     input logic [31:0] wd);
    @(posedge pclk);
    req <= {1'b1, 1'b0, w, ad, wd};
    @(posedge pclk);
    req.penable <= 1'b1;
    do @(posedge pclk); while (rsp.pready !== 1'b1);
    rd  = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask
  task automatic rchk(input logic [11:0] ad, input logic [31:0] e);
    bus(1'b0, ad, 32'h0);
    `CHK("register", e, rd)
  endtask
  task automatic pins(input logic [4:0] v, input logic [10:0] e);
    want <= v;
    repeat (5) @(posedge pclk);
    `CHK("in_func", e, in_func)
  endtask
  task automatic outs(input logic [11:0] f, input logic [2:0] e);
    of <= f;
    repeat (4) @(posedge pclk);
    `CHK("out_pin", e, seen)
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Cuts a hang short; a clean run needs well under 1000 cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      stop_test();
    end
  end
  // Main sequence
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rchk(12'h000, 32'h3210);
    rchk(12'h004, 32'h5);
    rchk(12'h008, 32'h210);
    rchk(12'h00c, 32'h0);
    bus(1'b1, 12'h01c, 32'hffff);
    rchk(12'h01c, 32'h0);
    `CHK("pslverr", 1'b1, err)
    pins(5'h15, 11'h025);
    outs(12'h010, 3'b000);
    outs(12'h006, 3'b110);
    rchk(12'h010, 32'h025);
    rchk(12'h014, 32'h006);
    rchk(12'h018, 32'hd5);
    bus(1'b1, 12'h004, 32'hf);
    for (int k = 0; k < 11; k++) begin
      bus(1'b1, 12'h000, 32'hfff0 | k);
      pins(5'h01, 11'(1 << k));
    end
    bus(1'b1, 12'h000, 32'h1111);
    bus(1'b1, 12'h004, 32'h1);
    pins(5'h0f, 11'h000);
    pins(5'h10, 11'h002);
    slow <= 1'b1;
    bus(1'b1, 12'h00c, 32'h11);
    pins(5'h00, 11'h002);
    bus(1'b1, 12'h00c, 32'he0);
    for (int k = 0; k < 16; k++) begin
      code = 4'(k);
      m = code < 4'h9 ? 12'(1) << code : code == 4'hd ? 12'h800 :
          (code == 4'ha || code == 4'hb) ? 12'(1) << (code - 1) : 12'h0;
      bus(1'b1, 12'h008, {20'h0, 8'hff, code});
      outs(m, {2'b11, m == 12'h0});
      outs(~m, 3'b111);
    end
    bus(1'b1, 12'h00c, 32'h0);
    bus(1'b1, 12'h008, 32'h4ff);
    outs(12'h010, 3'b100);
    stop_test();
  end
endmodule
